/* File: src/dfa_chan.sv */
/*
  Quick_acquire sequencer of one loop_channel: trigger qualification, bandwidth
  steps, settle and timeout timers, active and done flags.
  Assumes a one-cycle millisecond tick and a one-cycle closed-loop entry pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module dfa_chan (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ms_tick_i,
  input wire logic start_i,
  input wire logic from_holdover_i,
  input wire logic lock_i,
  input wire logic toggling_i,
  input wire logic [3:0] trig_i,
  input wire logic [3:0] excess_i,
  input wire logic [2:0] timeout_sel_i,
  input wire logic [2:0] settle_sel_i,
  input wire logic clear_done_i,
  output logic active_o,
  output logic done_o,
  output logic [3:0] bw_shift_o
);
  function automatic dfa_pkg::dfa_ms_t timeout_ms(input logic [2:0] sel);
    case (sel)
      3'h0: timeout_ms = 17'h0000a;
      3'h1: timeout_ms = 17'h00032;
      3'h2: timeout_ms = 17'h00064;
      3'h3: timeout_ms = 17'h001f4;
      3'h4: timeout_ms = 17'h003e8;
      3'h5: timeout_ms = 17'h02710;
      3'h6: timeout_ms = 17'h0c350;
      default: timeout_ms = 17'h186a0;
    endcase
  endfunction : timeout_ms

  function automatic dfa_pkg::dfa_ms_t settle_ms(input logic [2:0] sel);
    case (sel)
      3'h0: settle_ms = 17'h00001;
      3'h1: settle_ms = 17'h0000a;
      3'h2: settle_ms = 17'h00032;
      3'h3: settle_ms = 17'h00064;
      3'h4: settle_ms = 17'h001f4;
      3'h5: settle_ms = 17'h003e8;
      3'h6: settle_ms = 17'h02710;
      default: settle_ms = 17'h0c350;
    endcase
  endfunction : settle_ms

  dfa_pkg::dfa_seq_state_t state_q;
  dfa_pkg::dfa_ms_t to_cnt_q;
  dfa_pkg::dfa_ms_t st_cnt_q;
  logic [3:0] step_q;
  logic active_q;
  logic done_q;
  logic qual;
  logic go;
  logic settled;
  logic timed_out;

  assign qual = (trig_i == 4'h0) |
    (trig_i[0] & ~from_holdover_i) |
    (trig_i[1] & from_holdover_i) |
    (trig_i[2] & ~done_q) |
    (trig_i[3] & ~toggling_i);
  assign go = start_i & qual & (excess_i != 4'h0) & (state_q == dfa_pkg::DFA_IDLE);
  assign settled = lock_i & (st_cnt_q >= settle_ms(settle_sel_i));
  assign timed_out = to_cnt_q >= timeout_ms(timeout_sel_i);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= dfa_pkg::DFA_IDLE;
      step_q <= 4'h0;
      to_cnt_q <= '0;
      st_cnt_q <= '0;
      active_q <= 1'b0;
    end else begin
      case (state_q)
        dfa_pkg::DFA_IDLE: begin
          if (go) begin
            state_q <= dfa_pkg::DFA_STEP;
            step_q <= excess_i;
            to_cnt_q <= '0;
            st_cnt_q <= '0;
            active_q <= 1'b1;
          end
        end
        dfa_pkg::DFA_STEP: begin
          if (ms_tick_i) begin
            if (settled | timed_out) begin
              to_cnt_q <= '0;
              st_cnt_q <= '0;
              if (step_q == 4'h0) begin
                state_q <= dfa_pkg::DFA_IDLE;
                active_q <= 1'b0;
              end else begin
                step_q <= step_q - 4'h1;
              end
            end else begin
              to_cnt_q <= to_cnt_q + 17'h00001;
              st_cnt_q <= lock_i ? st_cnt_q + 17'h00001 : 17'h00000;
            end
          end
        end
        default: begin
          state_q <= dfa_pkg::DFA_IDLE;
          step_q <= 4'h0;
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // Done is set on the final settled step; a set in the clear cycle wins.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
    end else if (state_q == dfa_pkg::DFA_STEP && ms_tick_i && settled && step_q == 4'h0) begin
      done_q <= 1'b1;
    end else if (clear_done_i) begin
      done_q <= 1'b0;
    end
  end

  assign active_o = active_q;
  assign done_o = done_q;
  assign bw_shift_o = step_q;
endmodule : dfa_chan
`default_nettype wire

/* File: src/dfa_params.svh */
/*
  Register indices, field positions, reset values and timing figures for the
  loop-channel quick_acquire, phase offset and clamp block.
  Assumes inclusion by bare name from the top module and the testbench.
*/
`ifndef DFA_PARAMS_SVH
`define DFA_PARAMS_SVH
`define DFA_IDX_LIMIT0 14'h1006
`define DFA_IDX_LIMIT1 14'h1406
`define DFA_IDX_PHLO0 14'h1015
`define DFA_IDX_PHHI0 14'h1016
`define DFA_IDX_PHLO1 14'h1415
`define DFA_IDX_PHHI1 14'h1416
`define DFA_IDX_EXCESS0 14'h1216
`define DFA_IDX_EXCESS1 14'h1616
`define DFA_IDX_SETTLE0 14'h1217
`define DFA_IDX_SETTLE1 14'h1617
`define DFA_IDX_IRQCLR0 14'h200b
`define DFA_IDX_IRQCLR1 14'h2010
`define DFA_IDX_TRIG0 14'h2106
`define DFA_IDX_TRIG1 14'h2206
`define DFA_IDX_DONECLR0 14'h2107
`define DFA_IDX_DONECLR1 14'h2207
`define DFA_IDX_IRQ0 14'h3010
`define DFA_IDX_IRQ1 14'h3015
`define DFA_IDX_STAT0 14'h3102
`define DFA_IDX_STAT1 14'h3202
`define DFA_TO_LSB 4
`define DFA_SETTLE_LSB 0
`define DFA_DONE_BIT 5
`define DFA_ACT_BIT 4
`define DFA_CLAMP_BIT 1
`define DFA_CLRDONE_BIT 3
`define DFA_IRQ_ON_BIT 6
`define DFA_IRQ_OFF_BIT 7
`define DFA_LIMIT_RST 24'hffffff
`define DFA_TW_SHIFT 12
`define DFA_CLK_MHZ 250
`define DFA_TICK_MS 1
`endif

/* File: src/dfa_pkg.sv */
/*
  Types shared by the quick_acquire sequencer and the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dfa_pkg;
  typedef enum logic [1:0] {
    DFA_IDLE = 2'b00,
    DFA_STEP = 2'b01
  } dfa_seq_state_t;
  typedef logic [13:0] dfa_idx_t;
  typedef logic [16:0] dfa_ms_t;
endpackage : dfa_pkg

/* File: src/dfa_top.sv */
/*
  Two loop_channel control blocks behind an APB slave: quick_acquire
  sequencer, feedback phase offset summing node and tuning word clamp.
  Assumes APB master signals synchronous to clk_sys_i and a single clock.
*/
// The APB register port was decided locally.
// What this block does
// - Three-bit timeout field at bits six to four
// - Each step waits lock plus settle, bounded
// - Timeout codes map ten ms to 100 s
// - Timeout expiry advances to next step
// - Final settled step sets done status bit
// - Four trigger qualifier bits at bits three-zero
// - No qualifier set means always quick acquire
// - Set qualifiers combine by OR, else normal
// - Freerun entry triggers when its bit set
// - Holdover entry triggers when its bit set
// - First-only triggers while done is zero
// - Self-clearing write bit clears done status
// - No-output triggers while outputs are quiet
// - Forty-bit signed offset added at feedback node
// - Positive offset delays output edges
// - Node also sums skew and delay compensation
// - Clamp always on, limit resets to maximum
// - Symmetric bound about free-run tuning word
// - Live clamped status at status bit one
// - Flags latch on clamp entry and exit
// - Flags hold until their clear bits written
// - Start at excess power, halve; zero disables
// - Unlock during settle restarts settle timer
// - Active and done at status bits four, five
`timescale 1ns/100ps
`default_nettype none
`include "dfa_params.svh"
module dfa_top #(
  parameter int MS_CYCLES = `DFA_TICK_MS * `DFA_CLK_MHZ * 1000,
  parameter int TW_W = 48,
  parameter int PH_W = 40
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] loop_start_i,
  input wire logic [1:0] from_holdover_i,
  input wire logic [1:0] phase_lock_i,
  input wire logic [1:0] outputs_toggling_i,
  input wire logic [2*TW_W-1:0] loop_tw_i,
  input wire logic [2*TW_W-1:0] freerun_tw_i,
  input wire logic [2*PH_W-1:0] fb_phase_i,
  input wire logic [2*PH_W-1:0] skew_i,
  input wire logic [2*PH_W-1:0] delay_comp_i,
  output logic [2*PH_W-1:0] fb_phase_o,
  output logic [2*TW_W-1:0] tw_o,
  output logic [7:0] bw_shift_o
);
  localparam dfa_pkg::dfa_idx_t IDX_LIM [2] = '{`DFA_IDX_LIMIT0, `DFA_IDX_LIMIT1};
  localparam dfa_pkg::dfa_idx_t IDX_PHLO [2] = '{`DFA_IDX_PHLO0, `DFA_IDX_PHLO1};
  localparam dfa_pkg::dfa_idx_t IDX_PHHI [2] = '{`DFA_IDX_PHHI0, `DFA_IDX_PHHI1};
  localparam dfa_pkg::dfa_idx_t IDX_EXC [2] = '{`DFA_IDX_EXCESS0, `DFA_IDX_EXCESS1};
  localparam dfa_pkg::dfa_idx_t IDX_SET [2] = '{`DFA_IDX_SETTLE0, `DFA_IDX_SETTLE1};
  localparam dfa_pkg::dfa_idx_t IDX_ICL [2] = '{`DFA_IDX_IRQCLR0, `DFA_IDX_IRQCLR1};
  localparam dfa_pkg::dfa_idx_t IDX_TRG [2] = '{`DFA_IDX_TRIG0, `DFA_IDX_TRIG1};
  localparam dfa_pkg::dfa_idx_t IDX_DCL [2] = '{`DFA_IDX_DONECLR0, `DFA_IDX_DONECLR1};
  localparam dfa_pkg::dfa_idx_t IDX_IRQ [2] = '{`DFA_IDX_IRQ0, `DFA_IDX_IRQ1};
  localparam dfa_pkg::dfa_idx_t IDX_STA [2] = '{`DFA_IDX_STAT0, `DFA_IDX_STAT1};

  logic [23:0] limit_q [2];
  logic [PH_W-1:0] phoff_q [2];
  logic [3:0] excess_q [2];
  logic [2:0] to_sel_q [2];
  logic [2:0] st_sel_q [2];
  logic [3:0] trig_q [2];
  logic [1:0] irq_q [2];
  logic [1:0] clr_done_q;
  logic [1:0] clamped_q;
  logic [1:0] active;
  logic [1:0] done;
  logic [TW_W-1:0] tw_q [2];
  logic [PH_W-1:0] ph_q [2];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [17:0] tick_cnt_q;
  logic ms_tick_q;
  dfa_pkg::dfa_idx_t idx;
  logic wr;
  logic [31:0] rd_data;
  logic rd_hit;

  assign idx = paddr_i[15:2];
  assign wr = psel_i & penable_i & pwrite_i & pready_q & ~pslverr_q;

  // Millisecond timebase shared by both sequencers.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_q <= 18'h00000;
      ms_tick_q <= 1'b0;
    end else if (tick_cnt_q == 18'(MS_CYCLES - 1)) begin
      tick_cnt_q <= 18'h00000;
      ms_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
      ms_tick_q <= 1'b0;
    end
  end

  // Read decode; write-only and clear registers read as zero.
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b0;
    for (int c = 0; c < 2; c++) begin
      if (idx == IDX_LIM[c]) begin
        rd_hit = 1'b1;
        rd_data = {8'h00, limit_q[c]};
      end
      if (idx == IDX_PHLO[c]) begin
        rd_hit = 1'b1;
        rd_data = phoff_q[c][31:0];
      end
      if (idx == IDX_PHHI[c]) begin
        rd_hit = 1'b1;
        rd_data = {24'h000000, phoff_q[c][PH_W-1:32]};
      end
      if (idx == IDX_EXC[c]) begin
        rd_hit = 1'b1;
        rd_data = {28'h0000000, excess_q[c]};
      end
      if (idx == IDX_SET[c]) begin
        rd_hit = 1'b1;
        rd_data[`DFA_TO_LSB+:3] = to_sel_q[c];
        rd_data[`DFA_SETTLE_LSB+:3] = st_sel_q[c];
      end
      if (idx == IDX_TRG[c]) begin
        rd_hit = 1'b1;
        rd_data = {28'h0000000, trig_q[c]};
      end
      if (idx == IDX_ICL[c] || idx == IDX_DCL[c]) begin
        rd_hit = 1'b1;
      end
      if (idx == IDX_IRQ[c]) begin
        rd_hit = 1'b1;
        rd_data[`DFA_IRQ_ON_BIT] = irq_q[c][0];
        rd_data[`DFA_IRQ_OFF_BIT] = irq_q[c][1];
      end
      if (idx == IDX_STA[c]) begin
        rd_hit = 1'b1;
        rd_data[`DFA_DONE_BIT] = done[c];
        rd_data[`DFA_ACT_BIT] = active[c];
        rd_data[`DFA_CLAMP_BIT] = clamped_q[c];
      end
    end
  end

  // APB answer: pready rises in the access phase, zero wait states.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (psel_i && !penable_i) begin
      pready_q <= 1'b1;
      pslverr_q <= ~rd_hit | (paddr_i[1:0] != 2'h0);
      prdata_q <= (rd_hit && !pwrite_i && paddr_i[1:0] == 2'h0) ? rd_data : 32'h00000000;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < 2; c++) begin
        limit_q[c] <= `DFA_LIMIT_RST;
        phoff_q[c] <= '0;
        excess_q[c] <= 4'h0;
        to_sel_q[c] <= 3'h0;
        st_sel_q[c] <= 3'h0;
        trig_q[c] <= 4'h0;
      end
    end else if (wr) begin
      for (int c = 0; c < 2; c++) begin
        if (idx == IDX_LIM[c]) begin
          limit_q[c] <= pwdata_i[23:0];
        end
        if (idx == IDX_PHLO[c]) begin
          phoff_q[c][31:0] <= pwdata_i;
        end
        if (idx == IDX_PHHI[c]) begin
          phoff_q[c][PH_W-1:32] <= pwdata_i[PH_W-33:0];
        end
        if (idx == IDX_EXC[c]) begin
          excess_q[c] <= pwdata_i[3:0];
        end
        if (idx == IDX_SET[c]) begin
          to_sel_q[c] <= pwdata_i[`DFA_TO_LSB+:3];
          st_sel_q[c] <= pwdata_i[`DFA_SETTLE_LSB+:3];
        end
        if (idx == IDX_TRG[c]) begin
          trig_q[c] <= pwdata_i[3:0];
        end
      end
    end
  end

  // Self-clearing done-clear strobe, one cycle after the write.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_done_q <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        clr_done_q[c] <= wr & (idx == IDX_DCL[c]) & pwdata_i[`DFA_CLRDONE_BIT];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [TW_W-1:0] fr;
      logic [TW_W-1:0] lp;
      logic signed [TW_W:0] diff;
      logic signed [TW_W:0] off;
      logic sq_clr;

      dfa_chan u_chan (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ms_tick_i(ms_tick_q),
        .start_i(loop_start_i[g]),
        .from_holdover_i(from_holdover_i[g]),
        .lock_i(phase_lock_i[g]),
        .toggling_i(outputs_toggling_i[g]),
        .trig_i(trig_q[g]),
        .excess_i(excess_q[g]),
        .timeout_sel_i(to_sel_q[g]),
        .settle_sel_i(st_sel_q[g]),
        .clear_done_i(clr_done_q[g]),
        .active_o(active[g]),
        .done_o(done[g]),
        .bw_shift_o(bw_shift_o[4*g+:4])
      );

      assign fr = freerun_tw_i[g*TW_W+:TW_W];
      assign lp = loop_tw_i[g*TW_W+:TW_W];
      assign diff = $signed({1'b0, lp}) - $signed({1'b0, fr});
      // Limit scaled from fs/2^36 units to the tuning word's 2^48 scale.
      assign off = (TW_W + 1)'({limit_q[g], {`DFA_TW_SHIFT{1'b0}}});

      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          tw_q[g] <= '0;
          clamped_q[g] <= 1'b0;
        end else if (diff > off) begin
          tw_q[g] <= TW_W'(fr + off[TW_W-1:0]);
          clamped_q[g] <= 1'b1;
        end else if (diff < -off) begin
          tw_q[g] <= TW_W'(fr - off[TW_W-1:0]);
          clamped_q[g] <= 1'b1;
        end else begin
          tw_q[g] <= lp;
          clamped_q[g] <= 1'b0;
        end
      end

      // Clamp edge flags; an edge in the clear cycle wins over the clear.
      assign sq_clr = wr & (idx == IDX_ICL[g]);
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          irq_q[g] <= 2'h0;
        end else begin
          if (tw_edge_on(clamped_q[g], diff, off)) begin
            irq_q[g][0] <= 1'b1;
          end else if (sq_clr && pwdata_i[`DFA_IRQ_ON_BIT]) begin
            irq_q[g][0] <= 1'b0;
          end
          if (clamped_q[g] && diff <= off && diff >= -off) begin
            irq_q[g][1] <= 1'b1;
          end else if (sq_clr && pwdata_i[`DFA_IRQ_OFF_BIT]) begin
            irq_q[g][1] <= 1'b0;
          end
        end
      end

      // Feedback summing node; a positive offset delays the output edges.
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ph_q[g] <= '0;
        end else begin
          ph_q[g] <= PH_W'(fb_phase_i[g*PH_W+:PH_W] + phoff_q[g]
            + skew_i[g*PH_W+:PH_W] + delay_comp_i[g*PH_W+:PH_W]);
        end
      end

      assign tw_o[g*TW_W+:TW_W] = tw_q[g];
      assign fb_phase_o[g*PH_W+:PH_W] = ph_q[g];
    end
  endgenerate

  function automatic logic tw_edge_on(input logic was, input logic signed [TW_W:0] d,
                                      input logic signed [TW_W:0] o);
    tw_edge_on = !was && (d > o || d < -o);
  endfunction : tw_edge_on

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  pready_one_cycle_a: assert property (pready_q |=> !pready_q)
    else $error("pready held longer than one cycle");
  bad_addr_err_a: assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0 |=> pslverr_q)
    else $error("misaligned access not refused");

  generate
    for (g = 0; g < 2; g++) begin : g_chk
      clamp_rise_a: assert property ($rose(clamped_q[g]) |-> irq_q[g][0])
        else $error("clamp entry flag not set");
      clamp_fall_a: assert property ($fell(clamped_q[g]) |-> irq_q[g][1])
        else $error("clamp exit flag not set");
      flag_hold_a: assert property (irq_q[g][0] && !(wr && idx == IDX_ICL[g]) |=> irq_q[g][0])
        else $error("clamp flag dropped without clear");
      done_clear_a: assert property (clr_done_q[g] && !active[g] |=> !done[g])
        else $error("done not cleared");
      clamp_bound_a: assert property (clamped_q[g] |->
        (tw_q[g] == TW_W'($past(g_ch[g].fr) + $past(g_ch[g].off[TW_W-1:0]))) ||
        (tw_q[g] == TW_W'($past(g_ch[g].fr) - $past(g_ch[g].off[TW_W-1:0]))))
        else $error("clamped word not at bound");
      phase_sum_a: assert property (##1 ph_q[g] == PH_W'($past(fb_phase_i[g*PH_W+:PH_W])
        + $past(phoff_q[g]) + $past(skew_i[g*PH_W+:PH_W]) + $past(delay_comp_i[g*PH_W+:PH_W])))
        else $error("feedback sum wrong");
      zero_excess_a: assert property (excess_q[g] == 4'h0 && !active[g] |=> !active[g])
        else $error("quick acquire ran with zero excess");
      step_bound_a: assert property (active[g] |-> bw_shift_o[4*g+:4] <= excess_q[g]
        || $changed(excess_q[g]) || $past(active[g], 1))
        else $error("start bandwidth above excess");
      acq_cov_a: cover property ($rose(active[g]) ##[1:1000] $fell(active[g]));
      done_cov_a: cover property ($rose(done[g]));
      clamp_cov_a: cover property ($rose(clamped_q[g]) ##[1:100] $fell(clamped_q[g]));
    end
  endgenerate
endmodule : dfa_top
`default_nettype wire

/* File: testbench/dfa_top_tb.sv */
/*
  Self-checking bench for dfa_top: APB registers, quick_acquire triggers and
  timeout, feedback phase sum, tuning word clamp and its latched flags.
  Assumes the design sources and dfa_params.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dfa_params.svh"
module dfa_top_tb;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o, rerr;
  logic [15:0] paddr_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
  logic [1:0] loop_start_i = 2'h0, from_holdover_i = 2'h0;
  logic [1:0] phase_lock_i = 2'h0, outputs_toggling_i = 2'h0;
  logic [95:0] loop_tw_i = 96'h0, freerun_tw_i = 96'h0, tw_o;
  logic [79:0] fb_phase_i = 80'h0, skew_i = 80'h0, delay_comp_i = 80'h0, fb_phase_o;
  logic [7:0] bw_shift_o;
  logic [39:0] off, a, b, c;
  logic [47:0] fr, lp;
  logic [23:0] lim;
  // Trigger cases: qualifier bits, from holdover, outputs toggling, start expected.
  logic [6:0] cs [10] = '{7'h01, 7'h20, 7'h21, 7'h10, 7'h15, 7'h0c, 7'h09, 7'h42, 7'h41, 7'h30};
  int errors = 0, checked = 0, cyc = 0, n;

  dfa_top #(.MS_CYCLES(4)) uut (.clk_sys_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .loop_start_i, .from_holdover_i,
    .phase_lock_i, .outputs_toggling_i, .loop_tw_i, .freerun_tw_i, .fb_phase_i, .skew_i,
    .delay_comp_i, .fb_phase_o, .tw_o, .bw_shift_o);

  always #2 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task summarize();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task check(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : check

  task apb(input logic w, input logic [15:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task wr(input logic [13:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask : wr

  task rd(input logic [13:0] i);
    apb(1'b0, {i, 2'b00}, 32'h0);
  endtask : rd

  // Pulses a closed-loop entry on channel 0 and checks the starting exponent.
  task go(input logic h, input logic [3:0] e);
    @(posedge clk_sys_i);
    loop_start_i[0] <= 1'b1;
    from_holdover_i[0] <= h;
    @(posedge clk_sys_i);
    loop_start_i[0] <= 1'b0;
    #1;
    check(bw_shift_o[3:0], e);
  endtask : go

  task idle(input logic [1:0] e);
    int k;
    k = 0;
    rd(`DFA_IDX_STAT0);
    check(rdat[4], 1'b1);
    while (rdat[4] !== 1'b0 && k < 200) begin
      rd(`DFA_IDX_STAT0);
      k++;
    end
    check(rdat[5:4], e);
  endtask : idle

  function automatic logic [47:0] clampf(input logic [47:0] l, f, input logic [23:0] m);
    logic [48:0] o;
    o = {13'h0, m, 12'h0};
    if ({1'b0, l} > {1'b0, f} + o) return f + o[47:0];
    if ({1'b0, l} + o < {1'b0, f}) return f - o[47:0];
    return l;
  endfunction : clampf

  initial begin
    void'($urandom(82655));
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(`DFA_IDX_LIMIT0);
    check(rdat, 32'h00ffffff);
    rd(`DFA_IDX_LIMIT1);
    check(rdat, 32'h00ffffff);
    apb(1'b0, {`DFA_IDX_LIMIT0, 2'b10}, 32'h0);
    check({rerr, rdat}, {1'b1, 32'h0});
    wr(`DFA_IDX_SETTLE0, 32'h70);
    rd(`DFA_IDX_SETTLE0);
    check(rdat, 32'h70);
    wr(`DFA_IDX_TRIG0, 32'h0f);
    rd(`DFA_IDX_TRIG0);
    check(rdat, 32'h0f);
    wr(`DFA_IDX_TRIG0, 32'h0);
    wr(`DFA_IDX_EXCESS0, 32'h0);
    phase_lock_i <= 2'b11;
    go(1'b0, 4'h0);
    wr(`DFA_IDX_EXCESS0, 32'h2);
    for (int i = 0; i < 10; i++) begin
      if (i == 2) begin
        wr(`DFA_IDX_DONECLR0, 32'h8);
        rd(`DFA_IDX_STAT0);
        check(rdat[5], 1'b0);
      end
      wr(`DFA_IDX_TRIG0, {28'h0, cs[i][6:3]});
      outputs_toggling_i[0] <= cs[i][1];
      go(cs[i][2], cs[i][0] ? 4'h2 : 4'h0);
      if (cs[i][0]) begin
        idle(2'b10);
      end
    end
    // Lock never comes, so each step must end on its 10 ms timeout.
    wr(`DFA_IDX_DONECLR0, 32'h8);
    wr(`DFA_IDX_SETTLE0, 32'h0);
    wr(`DFA_IDX_EXCESS0, 32'h1);
    phase_lock_i <= 2'b00;
    go(1'b0, 4'h1);
    repeat (20) @(posedge clk_sys_i);
    check(bw_shift_o[3:0], 4'h1);
    n = 0;
    while (bw_shift_o[3:0] !== 4'h0 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    check(n >= 16 && n <= 32, 1'b1);
    idle(2'b00);
    wr(`DFA_IDX_EXCESS1, 32'h3);
    @(posedge clk_sys_i);
    loop_start_i[1] <= 1'b1;
    @(posedge clk_sys_i);
    loop_start_i[1] <= 1'b0;
    @(posedge clk_sys_i);
    check(bw_shift_o[7:4], 4'h3);
    fr = 48'h1000_0000_0000;
    freerun_tw_i[47:0] <= fr;
    loop_tw_i[47:0] <= fr;
    wr(`DFA_IDX_LIMIT0, 32'h100);
    wr(`DFA_IDX_IRQCLR0, 32'hc0);
    rd(`DFA_IDX_IRQ0);
    check(rdat, 32'h0);
    loop_tw_i[47:0] <= fr + 48'h20_0000;
    rd(`DFA_IDX_IRQ0);
    check(rdat, 32'h40);
    check(tw_o[47:0], fr + 48'h10_0000);
    rd(`DFA_IDX_STAT0);
    check(rdat[1], 1'b1);
    loop_tw_i[47:0] <= fr;
    rd(`DFA_IDX_IRQ0);
    check(rdat, 32'hc0);
    wr(`DFA_IDX_IRQCLR0, 32'h40);
    rd(`DFA_IDX_IRQ0);
    check(rdat, 32'h80);
    wr(`DFA_IDX_IRQ0, 32'hff);
    wr(`DFA_IDX_IRQCLR0, 32'h80);
    rd(`DFA_IDX_IRQ0);
    check(rdat, 32'h0);
    for (int i = 0; i < 6; i++) begin
      fr = 48'h0100_0000_0000 + 48'($urandom());
      lp = fr + {10'h0, $urandom(), 6'h0} - 48'h20_0000_0000;
      lim = (i == 0) ? 24'hffffff : 24'($urandom());
      wr(`DFA_IDX_LIMIT1, {8'h0, lim});
      freerun_tw_i[95:48] <= fr;
      loop_tw_i[95:48] <= lp;
      rd(`DFA_IDX_STAT1);
      check(tw_o[95:48], clampf(lp, fr, lim));
      check(rdat[1], clampf(lp, fr, lim) !== lp);
    end
    for (int i = 0; i < 4; i++) begin
      off = (i == 0) ? 40'hfffffedb08 : {8'($urandom()), $urandom()};
      wr(`DFA_IDX_PHLO0, off[31:0]);
      wr(`DFA_IDX_PHHI0, {24'h0, off[39:32]});
      a = {8'($urandom()), $urandom()};
      b = {8'($urandom()), $urandom()};
      c = {8'($urandom()), $urandom()};
      fb_phase_i <= {a, a};
      skew_i <= {b, b};
      delay_comp_i <= {c, c};
      repeat (2) @(posedge clk_sys_i);
      #1;
      check(fb_phase_o[39:0], 40'(a + b + c + off));
      check(fb_phase_o[79:40], 40'(a + b + c));
    end
    summarize();
  end
endmodule : dfa_top_tb
`default_nettype wire
